// ===== hdl/mmdiac_pkg.sv
/*
 * Constants, types and bundles shared by the indirect MMD access control
 * block and its pointer memory.
 * Assumes a single 100 MHz management clock and a parallel register port
 * fed by the management frame logic that sits outside this block.
 */
// Function
// - Each MMD keeps its own pointer; accesses never touch other pointers.
// - The five-bit target device field routes every data window access.
// - Function bits 15:14; address function reaches the MMD's pointer.
// - Data functions reach the MMD register that its pointer designates.
// - Post-increment adds one to the pointer after every read or write.
// - Write-only increment: pointer advances after writes, not after reads.
// - A sixteen-bit read-write data window reaches pointer or MMD register.
package mmdiac_pkg;

	// ------------------------------------------------------------------
	// Register map and field layout
	// ------------------------------------------------------------------
	localparam int          MMDIAC_DW         = 16;
	localparam int          MMDIAC_AW         = 5;
	localparam int          MMDIAC_NUM_MMD    = 32;
	localparam logic [4:0]  MMDIAC_CTRL_OFS   = 5'h0D;
	localparam logic [4:0]  MMDIAC_DATA_OFS   = 5'h0E;
	localparam int          MMDIAC_FUNC_HI    = 15;
	localparam int          MMDIAC_FUNC_LO    = 14;
	localparam int          MMDIAC_DEV_HI     = 4;
	localparam int          MMDIAC_DEV_LO     = 0;
	localparam logic [15:0] MMDIAC_CTRL_RST   = 16'h0000;
	localparam logic [15:0] MMDIAC_DATA_RST   = 16'h0000;
	localparam logic [15:0] MMDIAC_PTR_RST    = 16'h0000;
	localparam logic [15:0] MMDIAC_PTR_STEP   = 16'h0001;
	localparam logic [15:0] MMDIAC_UNMAPPED   = 16'h0000;

	// ------------------------------------------------------------------
	// Access functions and sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MMDIAC_FN_ADDRESS   = 2'b00,
		MMDIAC_FN_DATA      = 2'b01,
		MMDIAC_FN_DATA_INC    = 2'b10,
		MMDIAC_FN_DATA_INC_WR = 2'b11
	} mmdiac_func_t;

	typedef enum logic [1:0] {
		MMDIAC_ST_IDLE = 2'b00,
		MMDIAC_ST_PTR  = 2'b01,
		MMDIAC_ST_MMD  = 2'b10
	} mmdiac_state_t;

	// ------------------------------------------------------------------
	// Request bundles
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        we;
		logic [4:0]  reg_addr;
		logic [15:0] wdata;
	} mmdiac_mgmt_req_t;

	typedef struct packed {
		logic        we;
		logic [4:0]  target_device_number;
		logic [15:0] reg_addr;
		logic [15:0] wdata;
	} mmdiac_mmd_req_t;

endpackage

// ===== hdl/mmdiac_ptr_mem.sv
/*
 * Small pointer memory: one address pointer word per MMD, one write
 * port and one read port whose data come out of a register.
 * Assumes synchronous active-low reset on the shared management clock.
 */
module mmdiac_ptr_mem
	import mmdiac_pkg::*;
#(
	parameter int DW    = MMDIAC_DW,
	parameter int AW    = MMDIAC_AW,
	parameter int DEPTH = MMDIAC_NUM_MMD
) (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	logic [DW-1:0] mem_ff [DEPTH];
	logic [DW-1:0] rd_data_ff;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Reset clears every pointer so each MMD starts from register zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= DW'(MMDIAC_PTR_RST);
			end
		end else if (wr_en) begin
			mem_ff[wr_addr] <= wr_data; // Only the addressed word
		end
	end

	// Registered read; held while rd_en is low so the caller may reuse it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data_ff <= DW'(MMDIAC_PTR_RST);
		end else if (rd_en) begin
			rd_data_ff <= mem_ff[rd_addr];
		end
	end

	assign rd_data = rd_data_ff;

endmodule

// ===== hdl/mmdiac_top.sv
/*
 * Indirect MMD access control: the control register and data window
 * through which a management master reaches per-MMD address pointers
 * and MMD registers, with optional pointer post-increment.
 * Assumes the management frame logic presents decoded register accesses
 * as one-cycle requests, and that the MMD side answers each request with
 * a one-cycle acknowledge carrying read data.
 */
module mmdiac_top
	import mmdiac_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              mgmt_req_valid,
	input  wire mmdiac_mgmt_req_t  mgmt_req,
	output logic                   mgmt_ack,
	output logic [15:0]            mgmt_rdata,
	output logic                   mgmt_busy,
	output logic                   mmd_req_valid,
	output mmdiac_mmd_req_t        mmd_req,
	input  wire logic              mmd_ack,
	input  wire logic [15:0]       mmd_rdata
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	mmdiac_state_t    state_ff;
	mmdiac_func_t     func_ff;
	logic [4:0]       tdev_ff;
	logic             cur_we_ff;
	logic [15:0]      cur_wdata_ff;
	logic             mgmt_ack_ff;
	logic [15:0]      mgmt_rdata_ff;
	logic             mmd_req_valid_ff;
	mmdiac_mmd_req_t  mmd_req_ff;
	logic             ptr_rd_en;
	logic [15:0]      ptr_rdata;
	logic             ptr_wr_en;
	logic [15:0]      nxt_ptr;
	logic             take_req;
	logic             hit_ctrl;
	logic             hit_data;

	// Compose the control register image; reserved ranges stay zero
	function automatic logic [15:0] ctrl_image(mmdiac_func_t fn,
	                                           logic [4:0] dev);
		logic [15:0] v;
		v = MMDIAC_CTRL_RST;
		v[MMDIAC_FUNC_HI:MMDIAC_FUNC_LO] = fn;
		v[MMDIAC_DEV_HI:MMDIAC_DEV_LO]   = dev;
		return v;
	endfunction

	// Does this function bump the pointer after the given access kind
	function automatic logic bumps(mmdiac_func_t fn, logic we);
		return (fn == MMDIAC_FN_DATA_INC) ||
		       ((fn == MMDIAC_FN_DATA_INC_WR) && we);
	endfunction

	// ------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------
	// Requests arriving while a window access is in flight are dropped;
	// mgmt_busy tells the frame logic to hold off instead
	assign take_req = mgmt_req_valid && (state_ff == MMDIAC_ST_IDLE);
	assign hit_ctrl = take_req && (mgmt_req.reg_addr == MMDIAC_CTRL_OFS);
	assign hit_data = take_req && (mgmt_req.reg_addr == MMDIAC_DATA_OFS);
	assign ptr_rd_en = hit_data;

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	// Only function and target device are stored; writes to the
	// reserved ranges fall away
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			func_ff <= mmdiac_func_t'(MMDIAC_CTRL_RST[MMDIAC_FUNC_HI:
			                                          MMDIAC_FUNC_LO]);
			tdev_ff <= MMDIAC_CTRL_RST[MMDIAC_DEV_HI:MMDIAC_DEV_LO];
		end else if (hit_ctrl && mgmt_req.we) begin
			func_ff <= mmdiac_func_t'(mgmt_req.wdata[MMDIAC_FUNC_HI:
			                                         MMDIAC_FUNC_LO]);
			tdev_ff <= mgmt_req.wdata[MMDIAC_DEV_HI:MMDIAC_DEV_LO];
		end
	end

	// Capture the data window access kind and payload
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_we_ff    <= 1'b0;
			cur_wdata_ff <= MMDIAC_DATA_RST;
		end else if (hit_data) begin
			cur_we_ff    <= mgmt_req.we;
			cur_wdata_ff <= mgmt_req.wdata;
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// IDLE -> PTR (pointer word fetched) -> IDLE for address function,
	// or -> MMD, waiting on the MMD side's acknowledge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= MMDIAC_ST_IDLE;
		end else begin
			unique case (state_ff)
				MMDIAC_ST_IDLE: begin
					if (hit_data) begin
						state_ff <= MMDIAC_ST_PTR;
					end
				end
				MMDIAC_ST_PTR: begin
					if (func_ff == MMDIAC_FN_ADDRESS) begin
						state_ff <= MMDIAC_ST_IDLE;
					end else begin
						state_ff <= MMDIAC_ST_MMD;
					end
				end
				MMDIAC_ST_MMD: begin
					if (mmd_ack) begin
						state_ff <= MMDIAC_ST_IDLE;
					end
				end
				default: begin
					state_ff <= MMDIAC_ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Pointer update
	// ------------------------------------------------------------------
	// Address writes load the pointer; completed data accesses may bump
	// it. The pointer word stays in the read register, so no re-fetch.
	always_comb begin
		ptr_wr_en = 1'b0;
		nxt_ptr   = ptr_rdata;
		if ((state_ff == MMDIAC_ST_PTR) && (func_ff == MMDIAC_FN_ADDRESS)
		    && cur_we_ff) begin
			ptr_wr_en = 1'b1;
			nxt_ptr   = cur_wdata_ff;
		end else if ((state_ff == MMDIAC_ST_MMD) && mmd_ack
		             && bumps(func_ff, cur_we_ff)) begin
			ptr_wr_en = 1'b1;
			nxt_ptr   = ptr_rdata + MMDIAC_PTR_STEP;
		end
	end

	mmdiac_ptr_mem #(
		.DW    (MMDIAC_DW),
		.AW    (MMDIAC_AW),
		.DEPTH (MMDIAC_NUM_MMD)
	) u_ptr_mem (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wr_en   (ptr_wr_en),
		.wr_addr (tdev_ff),
		.wr_data (nxt_ptr),
		.rd_en   (ptr_rd_en),
		.rd_addr (tdev_ff),
		.rd_data (ptr_rdata)
	);

	// ------------------------------------------------------------------
	// MMD side request
	// ------------------------------------------------------------------
	// Request stands from PTR exit until the MMD acknowledge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mmd_req_valid_ff <= 1'b0;
			mmd_req_ff       <= '0;
		end else if ((state_ff == MMDIAC_ST_PTR)
		             && (func_ff != MMDIAC_FN_ADDRESS)) begin
			mmd_req_valid_ff                <= 1'b1;
			mmd_req_ff.we                   <= cur_we_ff;
			mmd_req_ff.target_device_number <= tdev_ff;
			mmd_req_ff.reg_addr             <= ptr_rdata;
			mmd_req_ff.wdata                <= cur_wdata_ff;
		end else if (mmd_ack) begin
			mmd_req_valid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Management answer
	// ------------------------------------------------------------------
	// One-cycle acknowledge; unmapped offsets answer with zero data
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mgmt_ack_ff   <= 1'b0;
			mgmt_rdata_ff <= MMDIAC_UNMAPPED;
		end else begin
			mgmt_ack_ff <= 1'b0;
			if (take_req && !hit_data) begin
				mgmt_ack_ff   <= 1'b1;
				mgmt_rdata_ff <= hit_ctrl ? ctrl_image(func_ff, tdev_ff)
				                          : MMDIAC_UNMAPPED;
			end else if ((state_ff == MMDIAC_ST_PTR)
			             && (func_ff == MMDIAC_FN_ADDRESS)) begin
				mgmt_ack_ff   <= 1'b1;
				mgmt_rdata_ff <= ptr_rdata;
			end else if ((state_ff == MMDIAC_ST_MMD) && mmd_ack) begin
				mgmt_ack_ff   <= 1'b1;
				mgmt_rdata_ff <= cur_we_ff ? cur_wdata_ff : mmd_rdata;
			end
		end
	end

	// Busy flag registered so the output comes from a flip-flop
	logic busy_ff;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
		end else if (hit_data) begin
			busy_ff <= 1'b1;
		end else if (((state_ff == MMDIAC_ST_PTR)
		              && (func_ff == MMDIAC_FN_ADDRESS))
		             || ((state_ff == MMDIAC_ST_MMD) && mmd_ack)) begin
			busy_ff <= 1'b0;
		end
	end

	assign mgmt_ack      = mgmt_ack_ff;
	assign mgmt_rdata    = mgmt_rdata_ff;
	assign mgmt_busy     = busy_ff;
	assign mmd_req_valid = mmd_req_valid_ff;
	assign mmd_req       = mmd_req_ff;

endmodule

// ===== verification/mmdiac_assertions.sv
/* Port checks for the indirect MMD access control block.
   Assumes one clock and the synchronous active-low reset. */
module mmdiac_assertions
	import mmdiac_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire logic             mgmt_req_valid,
	input wire mmdiac_mgmt_req_t mgmt_req,
	input wire logic             mgmt_ack,
	input wire logic [15:0]      mgmt_rdata,
	input wire logic             mgmt_busy,
	input wire logic             mmd_req_valid,
	input wire mmdiac_mmd_req_t  mmd_req,
	input wire logic             mmd_ack,
	input wire logic [15:0]      mmd_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Helper
	// ----
	logic       take;
	logic       win;
	logic       cwr;
	logic [1:0] fn_ff;
	logic [4:0] dev_ff;
	// Busy covers every in-flight cycle, so the live MMD request term never blocks on its own
	assign take = mgmt_req_valid && !mgmt_busy && !mmd_req_valid;
	assign win = take && mgmt_req.reg_addr == MMDIAC_DATA_OFS;
	assign cwr = take && mgmt_req.we && mgmt_req.reg_addr == MMDIAC_CTRL_OFS;
	// Mirror of the control fields
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			fn_ff <= 2'h0;
			dev_ff <= 5'h00;
		end else if (cwr) begin
			fn_ff <= mgmt_req.wdata[15:14];
			dev_ff <= mgmt_req.wdata[4:0];
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	a_rsvd_read_zero: assert property (
		take && !win |=> mgmt_ack && mgmt_rdata[13:5] == 9'h000)
		else $error("register answer late or reserved bits set");
	a_addr_fn_ack: assert property (
		win && fn_ff == 2'h0 |=> mgmt_busy && !mgmt_ack
		##1 mgmt_ack && !mmd_req_valid)
		else $error("address function answer wrong");
	a_data_fn_req: assert property (
		win && fn_ff != 2'h0 |=> !mgmt_ack ##1 mmd_req_valid
		&& mmd_req.target_device_number == dev_ff
		&& mmd_req.we == $past(mgmt_req.we, 2))
		else $error("mmd request late or misrouted");
	a_req_hold: assert property (
		mmd_req_valid && !mmd_ack |=> mmd_req_valid && $stable(mmd_req))
		else $error("mmd request dropped or changed");
	a_rd_return: assert property (
		mmd_req_valid && mmd_ack && !mmd_req.we
		|=> mgmt_ack && mgmt_rdata == $past(mmd_rdata))
		else $error("read data not returned");
	a_wr_echo: assert property (
		mmd_req_valid && mmd_ack && mmd_req.we |=> mgmt_ack
		&& !mmd_req_valid && mgmt_rdata == $past(mmd_req.wdata))
		else $error("write not completed");
	a_idle_no_req: assert property (
		!mgmt_busy |-> !mmd_req_valid)
		else $error("mmd request while idle");
	a_busy_release: assert property (
		mgmt_ack |-> !mgmt_busy)
		else $error("busy held after answer");
endmodule

bind mmdiac_top mmdiac_assertions u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .mgmt_req_valid(mgmt_req_valid),
	.mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
	.mgmt_busy(mgmt_busy), .mmd_req_valid(mmd_req_valid),
	.mmd_req(mmd_req), .mmd_ack(mmd_ack), .mmd_rdata(mmd_rdata));

// ===== verification/mmdiac_mmd_model.sv
/* Behavioural MMD register space behind the block.
   Assumes the bench clock; answers after a random wait. */
module mmdiac_mmd_model
	import mmdiac_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            mmd_req_valid,
	input  wire mmdiac_mmd_req_t mmd_req,
	output logic                 mmd_ack,
	output logic [15:0]          mmd_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [logic [20:0]];
	logic [20:0] k;
	integer      seed = 32'h72F8;
	initial begin
		mmd_ack = 1'b0;
		mmd_rdata = 16'h0000;
	end
	// ----
	// Answer
	// ----
	// Data toggles outside the ack cycle so stale values never match
	always @(negedge ref_clk) begin
		k = {mmd_req.target_device_number, mmd_req.reg_addr};
		if (!mmd_ack && mmd_req_valid && $random(seed) & 1) begin
			if (mmd_req.we)
				mem[k] = mmd_req.wdata;
			mmd_ack <= 1'b1;
			mmd_rdata <= mem.exists(k) ? mem[k] : ~k[15:0];
		end else begin
			mmd_ack <= 1'b0;
			mmd_rdata <= ~mmd_rdata;
		end
	end
endmodule

// ===== verification/mmd_indirect_access_control_tb_top.sv
/* Self-checking bench for the indirect MMD access control block.
   Assumes the MMD model answers every request in a few cycles. */
module mmd_indirect_access_control_tb_top
	import mmdiac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic             ref_clk = 1'b0;
	logic             rst_n;
	logic             mgmt_req_valid;
	mmdiac_mgmt_req_t mreq;
	logic             mgmt_ack;
	logic             mgmt_busy;
	logic [15:0]      mgmt_rdata;
	logic             mmd_req_valid;
	mmdiac_mmd_req_t  mmd_req;
	logic             mmd_ack;
	logic [15:0]      mmd_rdata;
	logic [15:0]      exp_q[$];
	logic [21:0]      req_q[$];
	logic [15:0]      ptr [32];
	logic [15:0]      shadow [logic [20:0]];
	logic [1:0]       fn;
	logic [4:0]       dev;
	logic [31:0]      r;
	integer           n_fail = 0;
	integer           n_compared = 0;
	integer           seed = 32'h72F8;
	mmdiac_top uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.mgmt_req_valid(mgmt_req_valid), .mgmt_req(mreq),
		.mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .mgmt_busy(mgmt_busy),
		.mmd_req_valid(mmd_req_valid), .mmd_req(mmd_req),
		.mmd_ack(mmd_ack), .mmd_rdata(mmd_rdata));
	mmdiac_mmd_model u_mmd (.ref_clk(ref_clk), .mmd_req_valid(mmd_req_valid),
		.mmd_req(mmd_req), .mmd_ack(mmd_ack), .mmd_rdata(mmd_rdata));
	always #5 ref_clk = ~ref_clk;
	// ----
	// Checking
	// ----
	task automatic check(input string what, input logic [21:0] seen,
		input logic [21:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Each answer retires the oldest note of its queue
	always @(posedge ref_clk) begin
		if (mgmt_ack === 1'b1)
			check("rdata", 22'(mgmt_rdata), 22'(exp_q.pop_front()));
		if (mmd_req_valid === 1'b1 && mmd_ack === 1'b1)
			check("mmd_req", mmd_req[37:16], req_q.pop_front());
	end
	// Budget is far above the ~1300 cycles the sequence needs
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
	// ----
	// Driving
	// ----
	task automatic xfer(input logic w, input logic [4:0] a,
		input logic [15:0] d, input logic [15:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		mgmt_req_valid = 1'b1;
		mreq = '{we: w, reg_addr: a, wdata: d};
		@(negedge ref_clk);
		mgmt_req_valid = 1'b0;
		while (mgmt_ack !== 1'b1 && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		if (n == 40)
			n_fail++;
		@(negedge ref_clk);
	endtask
	// Control write answers with the image from before the write
	task automatic setc(input logic [15:0] d);
		xfer(1'b1, MMDIAC_CTRL_OFS, d, {fn, 9'h000, dev});
		fn = d[15:14];
		dev = d[4:0];
	endtask
	// Window access, predicted from the bench's own pointers
	task automatic win(input logic w, input logic [15:0] d);
		logic [20:0] k;
		logic [15:0] e;
		k = {dev, ptr[dev]};
		e = w ? d : (shadow.exists(k) ? shadow[k] : ~k[15:0]);
		if (fn == 2'h0) begin
			// Address accesses answer with the pointer as it stood before
			e = ptr[dev];
			if (w)
				ptr[dev] = d;
		end else begin
			req_q.push_back({w, k});
			if (w)
				shadow[k] = d;
		end
		if (fn == 2'h2 || (fn == 2'h3 && w))
			ptr[dev]++;
		xfer(w, MMDIAC_DATA_OFS, d, e);
	endtask
	initial begin
		rst_n = 1'b0;
		mgmt_req_valid = 1'b0;
		mreq = '0;
		fn = 2'h0;
		dev = 5'h00;
		foreach (ptr[i])
			ptr[i] = MMDIAC_PTR_RST;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		// Reset image, then reserved bits written with ones
		xfer(1'b0, MMDIAC_CTRL_OFS, 16'h0000, MMDIAC_CTRL_RST);
		win(1'b0, 16'h0000);
		setc(16'hFFE3);
		xfer(1'b0, MMDIAC_CTRL_OFS, 16'h0000, 16'hC003);
		xfer(1'b1, 5'h1F, 16'hFFFF, MMDIAC_UNMAPPED);
		xfer(1'b0, 5'h1F, 16'h0000, MMDIAC_UNMAPPED);
		// Pointer wraps past the top of the space
		setc(16'h001F);
		win(1'b1, 16'hFFFF);
		setc(16'h801F);
		win(1'b1, 16'h1234);
		win(1'b0, 16'h0000);
		setc(16'h001F);
		win(1'b0, 16'h0000);
		// Random mix over eight MMDs and all four functions
		repeat (300) begin
			r = $random(seed);
			if (r[2:0] == 3'h0)
				setc({r[31:30], 9'h000, 2'h0, r[5:3]});
			else
				win(r[6], r[31:16]);
		end
		repeat (5) @(negedge ref_clk);
		check("pending", 22'(exp_q.size() + req_q.size()), 22'h000000);
		finish_test();
	end
endmodule
